/* File: hdl/dsp_coproc_pkg.sv */
package dsp_coproc_pkg;
  localparam int SUM_W = 40;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam logic [SUM_W-1:0] SUM_RESET = 40'h00_0000_0000;
  // Instruction fields
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int OP_HI = 27;
  localparam int OP_LO = 20;
  localparam logic [7:0] MUL_OPCODE = 8'he2;
  localparam logic [6:0] XFER_OPCODE = 7'h62;
  localparam int SEL_HI = 19;
  localparam int SEL_LO = 16;
  localparam int RS_HI = 15;
  localparam int RS_LO = 12;
  localparam int RM_HI = 3;
  localparam int RM_LO = 0;
  localparam int ZERO_HI = 11;
  localparam int ZERO_LO = 8;
  localparam int ONE_BIT = 4;
  localparam int MSEL_HI = 7;
  localparam int MSEL_LO = 5;
  localparam int DIR_BIT = 20;
  localparam int XZERO_HI = 11;
  localparam int XZERO_LO = 4;
  localparam int XSEL_HI = 2;
  localparam int XSEL_LO = 0;
  localparam int XBIT = 17;
  localparam int YBIT = 16;
  localparam int CPA_BIT = 0;
  localparam logic [3:0] SEL_WORD = 4'h0;
  localparam logic [3:0] SEL_DUAL = 4'h8;
  localparam logic [1:0] SEL_HALF_TOP = 2'h3;
  localparam logic [2:0] SUM_SEL0 = 3'h0;

  typedef enum logic [2:0] {
    op_none,
    op_word,
    op_dual,
    op_half,
    op_write,
    op_read,
    op_undef
  } op_t;
endpackage : dsp_coproc_pkg

/* File: hdl/mac_arith_if.sv */
`timescale 1ns/1ns
interface mac_arith_if;
  logic [1:0] mode;
  logic half_x;
  logic half_y;
  logic [31:0] multiplier_reg;
  logic [31:0] multiplicand_reg;
  logic [39:0] product;
  modport calc (input mode, half_x, half_y, multiplier_reg,
    multiplicand_reg, output product);
  modport user (output mode, half_x, half_y, multiplier_reg,
    multiplicand_reg, input product);
endinterface : mac_arith_if

/* File: hdl/mac_product_calc.sv */
`timescale 1ns/1ns
module mac_product_calc (
  mac_arith_if.calc a
);
  function automatic logic [39:0] hmul(input logic [15:0] p,
    input logic [15:0] q);
    logic signed [31:0] r;
    r = $signed(p) * $signed(q);
    return {{8{r[31]}}, r};
  endfunction : hmul

  logic signed [63:0] wide;
  logic [15:0] hx;
  logic [15:0] hy;

  always_comb begin
    wide = $signed(a.multiplier_reg) * $signed(a.multiplicand_reg);
    hx = a.half_x ? a.multiplicand_reg[31:16] : a.multiplicand_reg[15:0];
    hy = a.half_y ? a.multiplier_reg[31:16] : a.multiplier_reg[15:0];
    case (a.mode)
      2'h0: a.product = wide[39:0]; // RQ16 RQ6
      2'h1: a.product = hmul(a.multiplier_reg[15:0],
        a.multiplicand_reg[15:0]) + hmul(a.multiplier_reg[31:16],
        a.multiplicand_reg[31:16]); // RQ7
      default: a.product = hmul(hx, hy); // RQ8
    endcase
  end
endmodule : mac_product_calc

/* File: hdl/dsp_coproc.sv */
`timescale 1ns/1ns
// Behaviour
// [RQ1] One 40-bit sum register is the only accumulator.
// [RQ2] Access bit 0 set allows all; clear raises undefined trap.
// [RQ3] Multiply format: fixed opcode 27:20, 11:8 zero, bit 4 set.
// [RQ4] Selector 0 word, 8 dual, 12..15 single-half; others unpredictable.
// [RQ5] Multiply accumulator selector 7:5 must be zero.
// [RQ6] Word form: signed multiply, add to sum.
// [RQ7] Dual form: two signed half products, sign-extended, both added.
// [RQ8] Single-half: x picks multiplicand half, y multiplier half.
// [RQ9] Execute only when condition field matches the flags.
// [RQ10] Transfer bit 20 direction; high reg 19:16, low 15:12.
// [RQ11] Write: low reg into 31:0, high reg byte into 39:32.
// [RQ12] Read: 31:0 to low reg, top byte sign-extended to high.
// [RQ13] Issuer places zeros in transfer bits 7:4.
// [RQ14] Transfer accumulator selector 2:0 must be zero.
// [RQ15] Sums wrap modulo 2^40, no saturation or flag.
// [RQ16] Word product truncated to 40 bits before adding.
module dsp_coproc (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic issue_i,
  input wire logic [31:0] instr_i,
  input wire logic [3:0] flags_i,
  input wire logic [13:0] access_bits_i,
  input wire logic [31:0] multiplier_reg_i,
  input wire logic [31:0] multiplicand_reg_i,
  input wire logic [31:0] upper_xfer_reg_i,
  input wire logic [31:0] lower_xfer_reg_i,
  output logic done_o,
  output logic undef_o,
  output logic rd_valid_o,
  output logic [31:0] upper_xfer_reg_o,
  output logic [31:0] lower_xfer_reg_o,
  output logic [39:0] sole_sum_register_o
);
  // Flags: N Z C V in bits 3..0
  function automatic logic cond_pass(input logic [3:0] c,
    input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    logic r;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    case (c[3:1])
      3'h0: r = z;
      3'h1: r = cy;
      3'h2: r = n;
      3'h3: r = v;
      3'h4: r = cy & ~z;
      3'h5: r = n == v;
      3'h6: r = ~z & (n == v);
      default: r = 1'b1;
    endcase
    if (c[3:1] != 3'h7 && c[0]) r = ~r;
    return r;
  endfunction : cond_pass

  mac_arith_if ar ();
  mac_product_calc calc (.a(ar.calc));

  logic [39:0] sum_reg; // RQ1
  logic [39:0] next_sum_reg;
  logic done;
  logic next_done;
  logic undef;
  logic next_undef;
  logic rdv;
  logic next_rdv;
  logic [31:0] up_q;
  logic [31:0] next_up_q;
  logic [31:0] lo_q;
  logic [31:0] next_lo_q;
  dsp_coproc_pkg::op_t op;
  logic is_mul;
  logic is_xfer;
  logic go;

  always_comb begin
    is_mul = instr_i[dsp_coproc_pkg::OP_HI:dsp_coproc_pkg::OP_LO]
      == dsp_coproc_pkg::MUL_OPCODE
      && instr_i[dsp_coproc_pkg::ZERO_HI:dsp_coproc_pkg::ZERO_LO] == 4'h0
      && instr_i[dsp_coproc_pkg::ONE_BIT]; // RQ3
    is_xfer = instr_i[dsp_coproc_pkg::OP_HI:21]
      == dsp_coproc_pkg::XFER_OPCODE
      && instr_i[11:8] == 4'h0; // RQ10
    go = cond_pass(instr_i[dsp_coproc_pkg::COND_HI:
      dsp_coproc_pkg::COND_LO], flags_i); // RQ9
    op = dsp_coproc_pkg::op_none;
    if (!issue_i) op = dsp_coproc_pkg::op_none;
    else if (!access_bits_i[dsp_coproc_pkg::CPA_BIT])
      op = dsp_coproc_pkg::op_undef; // RQ2
    else if (!go) op = dsp_coproc_pkg::op_none; // RQ9
    else if (is_mul) begin
      // Nonzero accumulator selector is unpredictable; treated as sum 0
      if (instr_i[19:16] == dsp_coproc_pkg::SEL_WORD)
        op = dsp_coproc_pkg::op_word; // RQ4 RQ5
      else if (instr_i[19:16] == dsp_coproc_pkg::SEL_DUAL)
        op = dsp_coproc_pkg::op_dual;
      else if (instr_i[19:18] == dsp_coproc_pkg::SEL_HALF_TOP)
        op = dsp_coproc_pkg::op_half;
      else op = dsp_coproc_pkg::op_none; // Unpredictable: signals done, sum unchanged
    end else if (is_xfer) begin
      op = instr_i[dsp_coproc_pkg::DIR_BIT] ? dsp_coproc_pkg::op_read
        : dsp_coproc_pkg::op_write; // RQ10 RQ14
    end
  end

  always_comb begin
    ar.mode = op == dsp_coproc_pkg::op_word ? 2'h0
      : op == dsp_coproc_pkg::op_dual ? 2'h1 : 2'h2;
    ar.half_x = instr_i[dsp_coproc_pkg::XBIT]; // RQ8
    ar.half_y = instr_i[dsp_coproc_pkg::YBIT];
    ar.multiplier_reg = multiplier_reg_i;
    ar.multiplicand_reg = multiplicand_reg_i;
  end

  always_comb begin
    next_sum_reg = sum_reg;
    next_up_q = up_q;
    next_lo_q = lo_q;
    next_done = 1'b0;
    next_undef = 1'b0;
    next_rdv = 1'b0;
    case (op)
      dsp_coproc_pkg::op_word, dsp_coproc_pkg::op_dual,
      dsp_coproc_pkg::op_half: begin
        next_sum_reg = sum_reg + ar.product; // RQ15 RQ6 RQ7 RQ8
        next_done = 1'b1;
      end
      dsp_coproc_pkg::op_write: begin
        next_sum_reg = {upper_xfer_reg_i[7:0], lower_xfer_reg_i}; // RQ11
        next_done = 1'b1;
      end
      dsp_coproc_pkg::op_read: begin
        next_lo_q = sum_reg[31:0]; // RQ12
        next_up_q = {{24{sum_reg[39]}}, sum_reg[39:32]}; // RQ12
        next_done = 1'b1;
        next_rdv = 1'b1;
      end
      dsp_coproc_pkg::op_undef: next_undef = 1'b1; // RQ2
      default: next_done = issue_i;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sum_reg <= dsp_coproc_pkg::SUM_RESET;
      up_q <= 32'h0000_0000;
      lo_q <= 32'h0000_0000;
      done <= 1'b0;
      undef <= 1'b0;
      rdv <= 1'b0;
    end else begin
      sum_reg <= next_sum_reg;
      up_q <= next_up_q;
      lo_q <= next_lo_q;
      done <= next_done;
      undef <= next_undef;
      rdv <= next_rdv;
    end
  end

  assign done_o = done;
  assign undef_o = undef;
  assign rd_valid_o = rdv;
  assign upper_xfer_reg_o = up_q;
  assign lower_xfer_reg_o = lo_q;
  assign sole_sum_register_o = sum_reg;

  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  denied_trap_a: assert property (issue_i
    && !access_bits_i[0] |=> undef && !done && $stable(sum_reg)) // RQ2
    else $error("denied access did not trap");
  cond_fail_a: assert property (issue_i && access_bits_i[0] && !go
    |=> $stable(sum_reg) && !rdv && !undef) // RQ9
    else $error("failed condition changed state");
  sum_write_a: assert property (op == dsp_coproc_pkg::op_write
    |=> sum_reg == {$past(upper_xfer_reg_i[7:0]),
    $past(lower_xfer_reg_i)}) // RQ11
    else $error("sum write wrong");
  sum_read_a: assert property (op == dsp_coproc_pkg::op_read
    |=> rdv && lo_q == $past(sum_reg[31:0])
    && up_q == {{24{$past(sum_reg[39])}}, $past(sum_reg[39:32])}) // RQ12
    else $error("sum read wrong");
  word_acc_a: assert property (op == dsp_coproc_pkg::op_word
    |=> sum_reg == $past(sum_reg) + $past(40'(
    $signed(multiplier_reg_i) * $signed(multiplicand_reg_i)))) // RQ6
    else $error("word accumulate wrong");
  dual_acc_a: assert property (op == dsp_coproc_pkg::op_dual
    |=> sum_reg == $past(sum_reg)
    + 40'($signed($past(multiplier_reg_i[15:0]))
    * $signed($past(multiplicand_reg_i[15:0])))
    + 40'($signed($past(multiplier_reg_i[31:16]))
    * $signed($past(multiplicand_reg_i[31:16])))) // RQ7
    else $error("dual accumulate wrong");
  half_tt_a: assert property (op == dsp_coproc_pkg::op_half
    && instr_i[17:16] == 2'h3 |=> sum_reg == $past(sum_reg)
    + 40'($signed($past(multiplier_reg_i[31:16]))
    * $signed($past(multiplicand_reg_i[31:16])))) // RQ8
    else $error("top-top accumulate wrong");
  mul_decode_a: assert property (issue_i && access_bits_i[0] && go
    && instr_i[27:20] == 8'he2 && instr_i[11:8] == 4'h0 && instr_i[4]
    && instr_i[19:16] == 4'h0 |-> op == dsp_coproc_pkg::op_word) // RQ3
    else $error("word form not decoded");
  bad_sel_a: assert property (op != dsp_coproc_pkg::op_none
    && instr_i[19:16] inside {4'h1, 4'h9} && is_mul
    |-> 1'b0) // RQ4
    else $error("reserved selector executed");
  idle_quiet_a: assert property (!issue_i
    |=> !done && !undef && $stable(sum_reg)) // RQ1
    else $error("state changed while idle");
  // A trap and a completion must never be reported together
  pulse_excl_a: assert property (!(done && undef)) // RQ2
    else $error("done and trap together");
  read_done_a: assert property (rdv |-> done) // RQ12
    else $error("read valid without done");
  xfer_hold_a: assert property (op != dsp_coproc_pkg::op_read
    |=> $stable(up_q) && $stable(lo_q)) // RQ12
    else $error("transfer outputs moved without read");
  xfer_decode_a: assert property (issue_i && access_bits_i[0] && go
    && instr_i[27:21] == 7'h62 && instr_i[11:8] == 4'h0
    |-> op inside {dsp_coproc_pkg::op_write,
    dsp_coproc_pkg::op_read}) // RQ10
    else $error("transfer not decoded");
  half_bb_a: assert property (op == dsp_coproc_pkg::op_half
    && instr_i[17:16] == 2'h0 |=> sum_reg == $past(sum_reg)
    + 40'($signed($past(multiplier_reg_i[15:0]))
    * $signed($past(multiplicand_reg_i[15:0])))) // RQ8
    else $error("bottom-bottom accumulate wrong");
  half_bt_a: assert property (op == dsp_coproc_pkg::op_half
    && instr_i[17:16] == 2'h1 |=> sum_reg == $past(sum_reg)
    + 40'($signed($past(multiplier_reg_i[31:16]))
    * $signed($past(multiplicand_reg_i[15:0])))) // RQ8
    else $error("bottom-top accumulate wrong");
  half_tb_a: assert property (op == dsp_coproc_pkg::op_half
    && instr_i[17:16] == 2'h2 |=> sum_reg == $past(sum_reg)
    + 40'($signed($past(multiplier_reg_i[15:0]))
    * $signed($past(multiplicand_reg_i[31:16])))) // RQ8
    else $error("top-bottom accumulate wrong");
  write_done_a: assert property (op == dsp_coproc_pkg::op_write
    |=> done && !rdv && !undef) // RQ11
    else $error("write did not complete");

  word_c: cover property (op == dsp_coproc_pkg::op_word);
  dual_c: cover property (op == dsp_coproc_pkg::op_dual);
  read_c: cover property (op == dsp_coproc_pkg::op_read);
  undef_c: cover property (op == dsp_coproc_pkg::op_undef);
  half_c: cover property (op == dsp_coproc_pkg::op_half);
endmodule : dsp_coproc

/* File: dv/core_issuer.sv */
`timescale 1ns/1ns
module core_issuer (
  input wire logic sys_clk_i,
  output logic issue_o,
  output logic [31:0] instr_o,
  output logic [31:0] mpy_o,
  output logic [31:0] mcd_o
);
  initial begin
    issue_o = 1'b0;
    instr_o = 32'h0;
    mpy_o = 32'h0;
    mcd_o = 32'h0;
  end
  task automatic drive(input logic [31:0] ins, a, b);
    @(negedge sys_clk_i);
    issue_o = 1'b1;
    instr_o = ins;
    mpy_o = a;
    mcd_o = b;
  endtask : drive
  // Released lines flip so stale values never look valid
  task automatic idle();
    @(negedge sys_clk_i);
    issue_o = 1'b0;
    instr_o = ~instr_o;
    mpy_o = ~mpy_o;
    mcd_o = ~mcd_o;
  endtask : idle
  task automatic mul(input logic [3:0] c, s, input logic [31:0] a, b);
    drive({c, dsp_coproc_pkg::MUL_OPCODE, s, 8'h0, 3'h0, 1'b1, 4'h0}, a, b);
  endtask : mul
  task automatic xfer(input logic [3:0] c, input logic d, input logic [31:0] a, b);
    drive({c, dsp_coproc_pkg::XFER_OPCODE, d, 16'h0, 1'b0, 3'h0}, a, b);
  endtask : xfer
endmodule : core_issuer

/* File: dv/dsp_coproc_tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module dsp_coproc_tb;
  logic sys_clk_i, rst_n_i, issue, done, undef, rdv;
  logic [3:0] flags;
  logic [13:0] acc_bits;
  logic [31:0] instr, mpy, mcd, up_o, lo_o;
  logic [39:0] sum, exp_sum;
  int err_count, n_compared, cycles;
  dsp_coproc uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .issue_i(issue),
    .instr_i(instr), .flags_i(flags), .access_bits_i(acc_bits),
    .multiplier_reg_i(mpy), .multiplicand_reg_i(mcd),
    .upper_xfer_reg_i(mpy), .lower_xfer_reg_i(mcd), .done_o(done),
    .undef_o(undef), .rd_valid_o(rdv), .upper_xfer_reg_o(up_o),
    .lower_xfer_reg_o(lo_o), .sole_sum_register_o(sum));
  core_issuer core (.sys_clk_i(sys_clk_i), .issue_o(issue), .instr_o(instr),
    .mpy_o(mpy), .mcd_o(mcd));
  function automatic logic [39:0] prod(input logic [3:0] s, input logic [31:0] a, b);
    logic signed [63:0] w;
    logic signed [15:0] ha, hb;
    w = $signed(a) * $signed(b);
    ha = s[0] ? a[31:16] : a[15:0];
    hb = s[1] ? b[31:16] : b[15:0];
    if (s == 4'h0) return w[39:0];
    if (s == 4'h8) return 40'($signed(a[15:0]) * $signed(b[15:0]))
      + 40'($signed(a[31:16]) * $signed(b[31:16]));
    if (s >= 4'hc) return 40'(ha * hb);
    return 40'h0;
  endfunction : prod
  task automatic final_report();
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic d, u, r);
    `CHK(done, d)
    `CHK(undef, u)
    `CHK(rdv, r)
    `CHK(sum, exp_sum)
  endtask : chk
  task automatic mac(input logic [3:0] c, s, input logic [31:0] a, b);
    core.mul(c, s, a, b);
    core.idle();
    exp_sum = exp_sum + prod(s, a, b);
    chk(1'b1, 1'b0, 1'b0);
  endtask : mac
  task automatic wr(input logic [31:0] a, b);
    core.xfer(4'he, 1'b0, a, b);
    core.idle();
    exp_sum = {a[7:0], b};
    chk(1'b1, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [31:0] eu, el);
    core.xfer(4'he, 1'b1, 32'h0, 32'h0);
    core.idle();
    chk(1'b1, 1'b0, 1'b1);
    `CHK(up_o, eu)
    `CHK(lo_o, el)
  endtask : rd
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    rst_n_i = 1'b0;
    flags = 4'h0;
    acc_bits = 14'h0001;
    exp_sum = 40'h0;
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i) rst_n_i = 1'b1;
    `CHK(sum, 40'h0)
    wr(32'h0000_0185, 32'h1234_5678);
    rd(32'hffff_ff85, 32'h1234_5678);
    wr(32'h0000_007f, 32'hffff_ffff);
    mac(4'he, 4'h0, 32'h1, 32'h1);
    rd(32'hffff_ff80, 32'h0);
    mac(4'he, 4'h0, 32'hffff_fffd, 32'h7);
    mac(4'he, 4'h0, 32'h7fff_ffff, 32'h8000_0001);
    mac(4'he, 4'h8, 32'h8000_0003, 32'h7fff_fffe);
    for (int i = 12; i < 16; i++) mac(4'he, 4'(i), 32'h8001_0002, 32'h0003_fffc);
    mac(4'he, 4'h4, 32'h5, 32'h5);
    core.mul(4'h0, 4'h0, 32'h5, 32'h5);
    core.idle();
    chk(1'b1, 1'b0, 1'b0);
    mac(4'h1, 4'h0, 32'h5, 32'h5);
    core.xfer(4'h0, 1'b0, 32'h1, 32'h1);
    core.idle();
    chk(1'b1, 1'b0, 1'b0);
    flags = 4'h4;
    mac(4'h0, 4'hf, 32'h0009_0000, 32'hfff0_0000);
    acc_bits = 14'h3ffe;
    core.mul(4'he, 4'h0, 32'h3, 32'h3);
    core.idle();
    chk(1'b0, 1'b1, 1'b0);
    acc_bits = 14'h0001;
    core.mul(4'he, 4'h0, 32'h3, 32'h3);
    core.mul(4'he, 4'h0, 32'h4, 32'hfffffff0);
    exp_sum = exp_sum + 40'h9;
    chk(1'b1, 1'b0, 1'b0);
    core.idle();
    exp_sum = exp_sum - 40'h40;
    chk(1'b1, 1'b0, 1'b0);
    final_report();
  end
endmodule : dsp_coproc_tb
